// *** src/srac_pkg.sv ***
// Purpose: shared constants and types for the serial register access block
// Assumes: words are shifted most significant bit first
// Notes: storage words are 24 bits; narrower registers use the low bits
package srac_pkg;

    // register select codes carried by the command target field
    localparam logic [2:0] SEL_CMD = 3'h0;
    localparam logic [2:0] SEL_SETUP = 3'h1;
    localparam logic [2:0] SEL_CLOCK = 3'h2;
    localparam logic [2:0] SEL_DATA = 3'h3;
    localparam logic [2:0] SEL_TEST = 3'h4;
    localparam logic [2:0] SEL_NOP = 3'h5;
    localparam logic [2:0] SEL_ZCAL = 3'h6;
    localparam logic [2:0] SEL_FCAL = 3'h7;

    // transfer widths in serial clock cycles
    localparam logic [4:0] W_NONE = 5'h00;
    localparam logic [4:0] W_BYTE = 5'h08;
    localparam logic [4:0] W_DATA = 5'h10;
    localparam logic [4:0] W_CAL = 5'h18;
    localparam int STORE_W = 24;

    // command byte: start bit, then seven bits, last one at count six
    localparam logic [4:0] CMD_LAST = 5'h06;
    localparam int FLUSH_ONES_DEF = 32;

    // reset values
    localparam logic [6:0] CMD_RST = 7'h00;
    localparam logic [23:0] SETUP_RST = 24'h000001;
    localparam logic [23:0] REG_RST = 24'h000000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_WR = 2'b10,
        ST_RD = 2'b11
    } srac_state_t;

    // command register layout, top bit first
    typedef struct packed {
        logic status;
        logic [2:0] target;
        logic dir;
        logic power_down_bit;
        logic [1:0] input_sel;
    } srac_cmd_t;

    // width of the access that a target select asks for
    function automatic logic [4:0] srac_width(input logic [2:0] sel);
        logic [4:0] w;
        w = W_BYTE;
        if (sel == SEL_DATA) begin
            w = W_DATA;
        end else if (sel == SEL_ZCAL || sel == SEL_FCAL) begin
            w = W_CAL;
        end else if (sel == SEL_NOP) begin
            w = W_NONE;
        end
        return w;
    endfunction : srac_width

endpackage : srac_pkg

// *** src/srac_sync.sv ***
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is an independent level or a toggle
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module srac_sync
    import srac_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk, // destination clock
    input wire logic rst, // synchronous, active high; may be tied low
    input wire logic [W-1:0] d, // level from the other domain
    output logic [W-1:0] q // synchronised level
);

    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) begin
            $error("srac_sync: width must be at least one");
        end
    end

    // two stages; nothing else reads meta_q
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : srac_sync

// *** src/srac_ctrl.sv ***
// Purpose: serial command front end and register bank of a converter
// Assumes: host drives din and samples dout on rising sclk edges
// Notes: sclk is its own domain; conversion side runs on ref_clk
//
// Function
// - every transaction opens with a command write
// - reset leaves the interface idle awaiting command
// - command fixes direction and target of next access
// - after full-width access return to idle
// - 32 ones on din abandon transaction
// - seven registers and a no-op reachable through the command
// - command read returns conversion ready status
// - command register is eight bits, read/write
// - command also holds standby and channel select
// - ones in start bit hold the interface
// - three-bit target selects register and its width
// - direction zero writes, one reads
// - standby bit drives power down output
`timescale 1ns/1ps
module srac_ctrl
    import srac_pkg::*;
#(
    parameter int FLUSH_ONES = FLUSH_ONES_DEF
) (
    input wire logic ref_clk, // conversion side clock, 20 MHz
    input wire logic reset, // synchronous, active high
    input wire logic sclk, // serial clock from the host
    input wire logic din, // serial data in, sclk domain
    output logic dout, // serial data out, sclk domain
    input wire logic conv_done, // pulse: new conversion word ready
    input wire logic [15:0] conv_data, // held stable while ready
    output logic conversion_ready_flag_n, // low while unread data waits
    output logic power_down, // standby level, ref_clk domain
    output logic [1:0] input_sel // channel select, ref_clk domain
);

    initial begin
        if (FLUSH_ONES < 2 || FLUSH_ONES > 63) begin
            $error("srac_ctrl: FLUSH_ONES must lie in 2..63");
        end
    end

    localparam logic [5:0] FLUSH_LAST = 6'(FLUSH_ONES - 1);

    // link domain state
    srac_state_t state_q, state_d;
    logic [4:0] bit_cnt_q, bit_cnt_d;
    logic [5:0] ones_q, ones_d;
    logic [23:0] sh_q, sh_d;
    logic dout_q, dout_d;
    srac_cmd_t cmd_q;
    logic [23:0] mem_q [0:7];
    logic rd_tog_q;
    logic rst_l;
    logic rdy_l;
    logic [15:0] conv_l;

    // ref domain state
    logic ready_q;
    logic rd_tog_r, rd_tog_old_q;
    logic [2:0] ctl_r;
    logic [2:0] ctl_prev_q;

    // reset enters the link domain through a synchroniser
    srac_sync #(.W(1)) u_rst_sync (
        .clk(sclk),
        .rst(1'b0),
        .d(reset),
        .q(rst_l)
    );

    // conversion ready level into the link domain
    srac_sync #(.W(1)) u_rdy_sync (
        .clk(sclk),
        .rst(rst_l),
        .d(ready_q),
        .q(rdy_l)
    );

    // conversion word into the link domain; it is held while ready
    srac_sync #(.W(16)) u_data_sync (
        .clk(sclk),
        .rst(rst_l),
        .d(conv_data),
        .q(conv_l)
    );

    // read-done toggle and command control bits into ref domain
    srac_sync #(.W(4)) u_ref_sync (
        .clk(ref_clk),
        .rst(reset),
        .d({rd_tog_q, cmd_q.power_down_bit, cmd_q.input_sel}),
        .q({rd_tog_r, ctl_r})
    );

    // decode of the byte being shifted and the access in progress
    wire srac_cmd_t cmd_new = srac_cmd_t'({1'b0, sh_q[5:0], din});
    wire cmd_last = (state_q == ST_CMD) && (bit_cnt_q == CMD_LAST);
    wire [4:0] new_w = srac_width(cmd_new.target);
    wire [4:0] cur_w = srac_width(cmd_q.target);
    wire xfer_last = (bit_cnt_q == cur_w - 5'h01);
    wire flush = din && (ones_q == FLUSH_LAST);
    wire [23:0] wr_word = {sh_q[22:0], din};
    wire wr_ok = (cmd_q.target != SEL_DATA) && (cmd_q.target != SEL_NOP);
    wire rd_cmd_bit = ~rdy_l; // status bit reads low when data waits

    // read source: status with fresh command, conversion word or store
    wire [23:0] rd_raw = (cmd_new.target == SEL_CMD) ?
        {16'h0000, rd_cmd_bit, cmd_new[6:0]} :
        (cmd_new.target == SEL_DATA) ? {8'h00, conv_l} :
        mem_q[cmd_new.target];
    wire [23:0] rd_aligned = rd_raw << (5'(STORE_W) - new_w);

    // next state of the serial sequencer
    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q + 5'h01;
        unique case (state_q)
            ST_IDLE: begin
                bit_cnt_d = 5'h00;
                if (!din) begin
                    state_d = ST_CMD;
                end
            end
            ST_CMD: begin
                if (cmd_last) begin
                    bit_cnt_d = 5'h00;
                    if (new_w == W_NONE) begin
                        state_d = ST_IDLE;
                    end else if (cmd_new.dir) begin
                        state_d = ST_RD;
                    end else if (cmd_new.target == SEL_CMD) begin
                        state_d = ST_IDLE; // next byte is a command anyway
                    end else begin
                        state_d = ST_WR;
                    end
                end
            end
            ST_WR, ST_RD: begin
                if (xfer_last) begin
                    state_d = ST_IDLE;
                    bit_cnt_d = 5'h00;
                end
            end
        endcase
        if (flush) begin
            state_d = ST_IDLE;
            bit_cnt_d = 5'h00;
        end
    end

    // shifter and output bit; read data leaves msb first
    always_comb begin
        sh_d = {sh_q[22:0], din};
        dout_d = 1'b0;
        if (cmd_last && cmd_new.dir) begin
            sh_d = rd_aligned;
            dout_d = rd_aligned[23];
        end else if (state_q == ST_RD && !xfer_last) begin
            sh_d = {sh_q[22:0], 1'b0};
            dout_d = sh_q[22];
        end
        if (flush) begin
            dout_d = 1'b0;
        end
    end

    // run of ones on din
    assign ones_d = !din ? 6'h00 : (flush ? 6'h00 : ones_q + 6'h01);

    // sequencer registers
    always_ff @(posedge sclk) begin
        if (rst_l) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 5'h00;
            ones_q <= 6'h00;
            sh_q <= REG_RST;
            dout_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            ones_q <= ones_d;
            sh_q <= sh_d;
            dout_q <= dout_d;
        end
    end

    // command register: standby and channel live here too
    always_ff @(posedge sclk) begin
        if (rst_l) begin
            cmd_q <= srac_cmd_t'({1'b0, CMD_RST});
        end else if (cmd_last && !flush) begin
            cmd_q <= cmd_new;
        end
    end

    // register store; data and no-op words are not writable
    always_ff @(posedge sclk) begin
        if (rst_l) begin
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= REG_RST;
            end
            mem_q[SEL_SETUP] <= SETUP_RST;
        end else if (state_q == ST_WR && xfer_last && wr_ok && !flush) begin
            mem_q[cmd_q.target] <= wr_word;
        end
    end

    // a finished data read is signalled by a toggle, safe across clocks
    always_ff @(posedge sclk) begin
        if (rst_l) begin
            rd_tog_q <= 1'b0;
        end else if (state_q == ST_RD && xfer_last && !flush &&
                     cmd_q.target == SEL_DATA) begin
            rd_tog_q <= ~rd_tog_q;
        end
    end

    assign dout = dout_q;

    // ready: a new word wins over a read that clears it
    wire rd_seen = rd_tog_r ^ rd_tog_old_q;
    // control bits are taken only when two samples agree, so a skewed
    // multi-bit change never shows; commands come far enough apart
    wire ctl_steady = (ctl_r == ctl_prev_q);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ready_q <= 1'b0;
            rd_tog_old_q <= 1'b0;
            conversion_ready_flag_n <= 1'b1;
            ctl_prev_q <= 3'h0;
            power_down <= 1'b0;
            input_sel <= 2'h0;
        end else begin
            ready_q <= conv_done | (ready_q & ~rd_seen);
            rd_tog_old_q <= rd_tog_r;
            conversion_ready_flag_n <= ~(conv_done | (ready_q & ~rd_seen));
            ctl_prev_q <= ctl_r;
            if (ctl_steady) begin
                power_down <= ctl_r[2];
                input_sel <= ctl_r[1:0];
            end
        end
    end

    // checks on the link sequencer
    sequence cmd_start_s;
        state_q == ST_IDLE && !din && !flush;
    endsequence
    sequence cmd_body_s;
        (state_q == ST_CMD) [*7] ##1 (state_q != ST_CMD);
    endsequence

    idle_after_reset_a: assert property (@(posedge sclk)
        rst_l |=> state_q == ST_IDLE)
        else $error("not idle after reset");
    start_bit_hold_a: assert property (@(posedge sclk)
        disable iff (rst_l) state_q == ST_IDLE && din |=> state_q == ST_IDLE)
        else $error("left idle on a one start bit");
    command_length_a: assert property (@(posedge sclk)
        disable iff (rst_l) cmd_start_s |=> cmd_body_s)
        else $error("command byte not eight bits");
    flush_idle_a: assert property (@(posedge sclk)
        disable iff (rst_l)
        din && ones_q == FLUSH_LAST |=> state_q == ST_IDLE && ones_q == 0)
        else $error("ones run did not restore idle");
    read_select_a: assert property (@(posedge sclk)
        disable iff (rst_l)
        cmd_last && !flush && cmd_new.dir && new_w != W_NONE
        |=> state_q == ST_RD && cmd_q.target == $past(cmd_new.target))
        else $error("read command did not start a read");
    access_done_a: assert property (@(posedge sclk)
        disable iff (rst_l)
        (state_q == ST_WR || state_q == ST_RD) && xfer_last
        |=> state_q == ST_IDLE)
        else $error("no return to idle after access");
    status_bit_a: assert property (@(posedge sclk)
        disable iff (rst_l)
        cmd_last && !flush && cmd_new.dir && cmd_new.target == SEL_CMD
        |=> dout_q == $past(rd_cmd_bit))
        else $error("status bit not first out");
    data_width_a: assert property (@(posedge sclk)
        disable iff (rst_l)
        state_q == ST_RD && cmd_q.target == SEL_DATA && bit_cnt_q == 5'h0e
        && !flush |=> state_q == ST_RD ##1 state_q == ST_IDLE)
        else $error("data read not sixteen bits");

endmodule : srac_ctrl

// *** tb/srac_host.sv ***
// Purpose: host side of the serial link, makes sclk and shifts words
// Assumes: device samples din and updates dout on rising sclk
// Notes: sclk stands still low between frames; din idles high
`timescale 1ns/1ps
module srac_host (
    output logic sclk, // serial clock, 15 ns period
    output logic din, // serial data to the device
    input wire logic dout // serial data from the device
);
    initial begin
        sclk = 1'b0;
        din = 1'b1;
    end

    // one frame msb first; rx collects dout as seen at each rising edge
    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            din = tx[i];
            #7.5;
            rx = {rx[30:0], dout};
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
        end
        // ones can never open a frame, so a released line idles high;
        // the gaps keep din from changing twice in one time step
        #7.5 din = 1'b1;
        #7.5;
    endtask : xfer
endmodule : srac_host

// *** tb/serial_register_access_ctrl_tb_top.sv ***
// Purpose: register access tests over the serial link
// Assumes: flush count shortened to 8 ones
// Notes: reads return the low width bits of each stored word
`timescale 1ns/1ps
module serial_register_access_ctrl_tb_top import srac_pkg::*;;
    localparam int FLUSH = 8;
    logic ref_clk, reset, sclk, din, dout, conv_done;
    logic [15:0] conv_data;
    logic conversion_ready_flag_n, power_down;
    logic [1:0] input_sel;
    logic [31:0] v;
    int bad_count = 0;
    int n_checks = 0;
    logic [2:0] sel_t [5] = '{SEL_SETUP, SEL_CLOCK, SEL_TEST, SEL_ZCAL,
                              SEL_FCAL};
    int wid_t [5] = '{8, 8, 8, 24, 24};
    logic [31:0] rst_t [5] = '{32'h01, 32'h00, 32'h00, 32'h00, 32'h00};
    logic [31:0] val_t [5] = '{32'ha5, 32'h3c, 32'h5a, 32'hc3a55a,
                               32'h5aa5c3};

    srac_ctrl #(.FLUSH_ONES(FLUSH)) i_dut (.ref_clk(ref_clk),
        .reset(reset), .sclk(sclk), .din(din), .dout(dout),
        .conv_done(conv_done), .conv_data(conv_data),
        .conversion_ready_flag_n(conversion_ready_flag_n),
        .power_down(power_down), .input_sel(input_sel));
    srac_host i_host (.sclk(sclk), .din(din), .dout(dout));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] mk(input logic [2:0] s, input logic d);
        return {1'b0, s, d, 3'h0};
    endfunction : mk

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // command then the selected width, back to back
    task automatic rd(input logic [2:0] s, input int w,
                      output logic [31:0] d);
        logic [31:0] r;
        i_host.xfer({24'h0, mk(s, 1'b1)} << w, 8 + w, r);
        d = r & ((32'h1 << w) - 1);
    endtask : rd

    task automatic wr(input logic [2:0] s, input int w, input logic [31:0] d);
        logic [31:0] r;
        i_host.xfer(({24'h0, mk(s, 1'b0)} << w) | d, 8 + w, r);
    endtask : wr

    // flag crosses clock domains, so allow a bounded settle
    task automatic flag_wait(input logic e);
        for (int i = 0; i < 20 && conversion_ready_flag_n !== e; i++) begin
            @(posedge ref_clk);
        end
        chk("ready_flag", e, conversion_ready_flag_n);
    endtask : flag_wait

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        #400000;
        bad_count++;
        conclude();
    end

    initial begin
        reset = 1'b1;
        conv_done = 1'b0;
        conv_data = 16'h0;
        // link reset needs sclk edges while reset is high
        fork
            repeat (3) @(posedge ref_clk);
            i_host.xfer(32'hffffffff, 6, v);
        join
        @(posedge ref_clk);
        #1 reset = 1'b0;
        i_host.xfer(32'hffffffff, 4, v);
        chk("ready_flag", 1'b1, conversion_ready_flag_n);
        chk("power_down", 1'b0, power_down);
        chk("input_sel", 2'h0, input_sel);
        $display("test reset done");
        // every stored register: reset value, write, read back
        for (int i = 0; i < 5; i++) begin
            rd(sel_t[i], wid_t[i], v);
            chk("reset_word", rst_t[i], v);
            wr(sel_t[i], wid_t[i], val_t[i]);
            rd(sel_t[i], wid_t[i], v);
            chk("read_word", val_t[i], v);
        end
        $display("test registers done");
        // ones ahead of the start bit, then standby and channel 3
        i_host.xfer({21'h0, 3'b111, 8'h07}, 11, v);
        repeat (5) @(posedge ref_clk);
        #1;
        chk("power_down", 1'b1, power_down);
        chk("input_sel", 2'h3, input_sel);
        rd(SEL_CMD, 8, v);
        chk("cmd_read", {24'h0, 1'b1, 7'h08}, v);
        repeat (5) @(posedge ref_clk);
        #1;
        chk("power_down", 1'b0, power_down);
        // no-op has no data phase: next command follows at once
        i_host.xfer({24'h0, mk(SEL_NOP, 1'b0)}, 8, v);
        i_host.xfer({24'h0, mk(SEL_NOP, 1'b1)}, 8, v);
        rd(SEL_SETUP, 8, v);
        chk("after_nop", 32'ha5, v);
        $display("test command done");
        // a run of ones abandons a half sent calibration write
        i_host.xfer({12'h0, 8'h60, 4'h0, 8'hff}, 20, v);
        rd(SEL_ZCAL, 24, v);
        chk("after_flush", 32'hc3a55a, v);
        $display("test flush done");
        @(posedge ref_clk);
        #1 conv_data = 16'hbeef;
        conv_done = 1'b1;
        @(posedge ref_clk);
        #1 conv_done = 1'b0;
        chk("ready_flag", 1'b0, conversion_ready_flag_n);
        rd(SEL_CMD, 8, v);
        chk("cmd_status", {24'h0, 1'b0, 7'h08}, v);
        wr(SEL_DATA, 16, 32'h1234);
        rd(SEL_DATA, 16, v);
        chk("data_read", 32'hbeef, v);
        flag_wait(1'b1);
        rd(SEL_CMD, 8, v);
        chk("cmd_status", {24'h0, 1'b1, 7'h08}, v);
        $display("test ready done");
        conclude();
    end
endmodule : serial_register_access_ctrl_tb_top
